/* tb/ihp_properties.sv */
// Purpose: port checks for the serial host pin, gate and interrupt block
// Assumes: only top ports visible, one clock domain
// Notes:   bound to every ihp_top instance
`timescale 1ns/1ps
module ihp_props
    import ihp_pkg::*;
(
    input wire logic              pclk, presetn, psel, penable, pready,   // apb and clock
    input wire logic              pslverr, irq, dma_irq, eng_busy, pg_req, // status inputs
    input wire logic              pg_gated, ltr_update,                   // gate and latency
    input wire logic [ADDR_W-1:0] paddr,                                  // apb address
    input wire logic [LTR_W-1:0]  ltr_value,                              // reported latency
    input wire logic              link_data_line_out, link_clock_line_out, // primary out
    input wire logic              link_alt_data_line_out, link_alt_clock_line_out, // alt out
    input wire logic              link_data_line_oe, link_clock_line_oe,  // primary drive
    input wire logic              link_alt_data_line_oe, link_alt_clock_line_oe // alt drive
);
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    AST_OD_LOW: assert property (!(link_data_line_out | link_clock_line_out | link_alt_data_line_out
        | link_alt_clock_line_out)) else $error("line driven high");
    AST_ONE_DATA_PAIR: assert property (!(link_data_line_oe && link_alt_data_line_oe)) else $error("two data pairs");
    AST_ONE_CLK_PAIR: assert property (!(link_clock_line_oe && link_alt_clock_line_oe)) else $error("two clk pairs");
    AST_UNMAPPED: assert property (psel && !penable && paddr > 8'h20 |=> pready && pslverr) else $error("no error");
    AST_DMA_IRQ: assert property (dma_irq |=> irq) else $error("dma request lost");
    AST_PG_TAKE: assert property (pg_req && !eng_busy && !pg_gated |=> pg_gated) else $error("gate not taken");
    AST_PG_HOLD: assert property ($rose(pg_gated) |-> pg_gated[*8]) else $error("gate step cut short");
    AST_PG_FREEZE: assert property ($rose(pg_gated) |=> ##1 $stable({link_data_line_oe, link_clock_line_oe,
        link_alt_data_line_oe, link_alt_clock_line_oe})[*8]) else $error("line moved in gate step");
    AST_LTR_UPD: assert property ($changed(ltr_value) |-> ltr_update) else $error("no latency strobe");
endmodule
bind ihp_top ihp_props chk_u (.*);

/* tb/ihp_target.sv */
// Purpose: wired open-drain bus with pull-ups on both pairs and a target on the primary pair only
// Assumes: released lines float high through the pull-ups
// Notes:   target may stretch the clock low on command
`timescale 1ns/1ps
module ihp_target (
    input  wire logic data_oe, clock_oe, alt_data_oe, alt_clock_oe, // host drive
    input  wire logic hold_clock, hold_data,                        // target stretch, data pull
    output logic      data_line, clock_line, alt_data_line, alt_clock_line // wire level
);
    // pull-up wins unless some party pulls low; target stays active while gated
    assign data_line      = !(data_oe | hold_data);
    assign clock_line     = !(clock_oe | hold_clock);
    assign alt_data_line  = !alt_data_oe;
    assign alt_clock_line = !alt_clock_oe;
endmodule

/* tb/tb.sv */
// Purpose: self-checking bench for ihp_top
// Assumes: apb master, random data from an lfsr seeded at 91
// Notes:   one pass through reset, registers, events, pins, gate, stuck
`timescale 1ns/1ps
module tb;
    import ihp_pkg::*;
`define CHK(a, b) begin samples_checked++; if ((a) !== (b)) begin miscompares++; \
    $display("[ERR] %0t got %h exp %h", $time, a, b); end end
    logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, err, hold_c = 0, hold_d = 0;
    logic pready, pslverr, irq, pg_gated, ltr_update;
    logic eng_sda_low = 0, eng_scl_low = 0, eng_busy = 0, eng_data_phase = 0;
    logic eng_nack = 0, eng_tx_done = 0, dma_irq = 0, pg_req = 0;
    logic [ADDR_W-1:0] paddr = '0;
    logic [DATA_W-1:0] pwdata = '0, prdata, r, hw_v;
    logic [LTR_W-1:0]  ltr_value, rnd = 16'h005b, sw_v;
    logic link_data_line_in, link_clock_line_in, link_alt_data_line_in, link_alt_clock_line_in;
    logic link_data_line_out, link_clock_line_out, link_alt_data_line_out, link_alt_clock_line_out;
    logic link_data_line_oe, link_clock_line_oe, link_alt_data_line_oe, link_alt_clock_line_oe;
    int   miscompares = 0, samples_checked = 0;
    always #12.5 pclk = ~pclk;
    ihp_top #(.CTRL_INDEX(2)) dut_u (.*);
    ihp_target far_u (.data_oe(link_data_line_oe), .clock_oe(link_clock_line_oe),
        .alt_data_oe(link_alt_data_line_oe), .alt_clock_oe(link_alt_clock_line_oe), .hold_clock(hold_c),
        .hold_data(hold_d), .data_line(link_data_line_in), .clock_line(link_clock_line_in),
        .alt_data_line(link_alt_data_line_in), .alt_clock_line(link_alt_clock_line_in));
    function automatic logic [15:0] lfsr(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction
    // expected latency for mode and activity
    function automatic logic [15:0] exp_ltr(input logic sw, input logic act);
        return sw ? sw_v : (act ? hw_v[15:0] : hw_v[31:16]);
    endfunction
    // one apb transfer, held until pready
    task apb(input logic w, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
        @(posedge pclk); psel <= 1; penable <= 0; pwrite <= w; paddr <= a; pwdata <= d;
        @(posedge pclk); penable <= 1;
        do begin @(posedge pclk); end while (pready !== 1'b1);
        r = prdata; err = pslverr; psel <= 0; penable <= 0;
    endtask
    task stop_test;
        if (miscompares == 0 && samples_checked > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    initial begin
        #200us; miscompares++; stop_test;
    end
    initial begin
        repeat (3) @(posedge pclk);
        presetn <= 1;
        apb(0, CTRL_OFS, '0); `CHK(r, 32'h0000_0000)
        apb(0, HOLD_OFS, '0); `CHK(r, 32'h0000_0004)
        apb(0, 8'h24, '0); `CHK({err, r}, {1'b1, 32'h0000_0000})
        rnd = lfsr(rnd); apb(1, HOLD_OFS, {16'h0000, rnd});
        apb(0, HOLD_OFS, '0); `CHK(r, {16'h0000, rnd})
        sw_v = lfsr(rnd); hw_v = {lfsr(sw_v), ~sw_v};
        apb(1, LTR_SW_OFS, {16'h0000, sw_v}); apb(1, LTR_HW_OFS, hw_v);
        // every latency mode, idle and active
        for (int m = 0; m < 4; m++) begin
            eng_busy <= m[0]; apb(1, CTRL_OFS, {30'h0000_0000, m[1], 1'b0});
            repeat (3) @(posedge pclk);
            `CHK(ltr_value, exp_ltr(m[1], m[0]))
            apb(0, LTR_CUR_OFS, '0); `CHK(r[15:0], exp_ltr(m[1], m[0]))
        end
        eng_busy <= 0; eng_nack <= 1; eng_tx_done <= 1;
        @(posedge pclk); eng_nack <= 0; eng_tx_done <= 0;
        apb(0, INT_ST_OFS, '0); `CHK(r, 32'h0000_0003)
        `CHK(irq, 1'b0)
        apb(1, INT_EN_OFS, 32'h0000_0002); repeat (2) @(posedge pclk); `CHK(irq, 1'b1)
        apb(1, INT_CLR_OFS, 32'h0000_0001); apb(0, INT_ST_OFS, '0); `CHK({irq, r}, {1'b1, 32'h0000_0002})
        apb(1, INT_CLR_OFS, 32'h0000_0002); repeat (2) @(posedge pclk); `CHK(irq, 1'b0)
        dma_irq <= 1; apb(0, STATUS_OFS, '0); `CHK({irq, r[4]}, 2'b11)
        dma_irq <= 0; eng_scl_low <= 1; repeat (3) @(posedge pclk);
        `CHK({link_clock_line_oe, link_clock_line_in}, 2'b10)
        apb(1, CTRL_OFS, 32'h0000_0001); repeat (3) @(posedge pclk);
        `CHK({link_clock_line_oe, link_alt_clock_line_oe, link_alt_clock_line_in}, 3'b010)
        eng_scl_low <= 0; apb(1, CTRL_OFS, 32'h0000_0008); pg_req <= 1;
        repeat (3) @(posedge pclk); `CHK(pg_gated, 1'b1)
        eng_sda_low <= 1; repeat (16) @(posedge pclk);
        `CHK({link_clock_line_oe, link_data_line_oe}, 2'b10)
        apb(0, INT_ST_OFS, '0); `CHK(r[EV_PG], 1'b1)
        eng_sda_low <= 0; pg_req <= 0; repeat (14) @(posedge pclk); `CHK(pg_gated, 1'b0)
        hold_c <= 1; hold_d <= 1; eng_data_phase <= 1; repeat (1020) @(posedge pclk); hold_c <= 0;
        apb(0, INT_ST_OFS, '0); `CHK(r[EV_STUCK:EV_ARB], 2'b11)
        stop_test;
    end
endmodule

/* verilog/ihp_ltr.sv */
// Purpose: picks the reported latency tolerance value and flags changes
// Assumes: mode, values and activity are stable for at least one cycle
// Notes:   update pulses once per change of the reported value
`timescale 1ns/1ps
module ihp_ltr
    import ihp_pkg::*;
(
    input  wire logic             pclk,       // block clock
    input  wire logic             presetn,    // async reset, low
    input  wire logic             sw_mode,    // driver supplies value
    input  wire logic             active,     // controller has work
    input  wire logic [LTR_W-1:0] sw_val,     // driver value
    input  wire logic [LTR_W-1:0] act_val,    // default value when active
    input  wire logic [LTR_W-1:0] idl_val,    // default value when idle
    output logic      [LTR_W-1:0] value,      // reported value
    output logic                  update      // one-cycle change strobe
);
    logic [LTR_W-1:0] value_next;

    // scheme select
    always_comb begin
        if (sw_mode) begin
            value_next = sw_val;
        end else begin
            value_next = active ? act_val : idl_val;
        end
    end

    // report to the power manager
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            value  <= LTR_IDL_RST;
            update <= 1'b0;
        end else begin
            value  <= value_next;
            update <= (value_next != value);
        end
    end
endmodule

/* verilog/ihp_pkg.sv */
// Purpose: shared constants for the serial host pin, power and interrupt block
// Assumes: 40 MHz pclk, 32-bit APB data, 8-bit byte address
// Notes:   offsets are byte addresses, one aligned word per register
package ihp_pkg;
    // ************************************************************
    // clock and timing
    // ************************************************************
    localparam int CLK_MHZ        = 40;
    localparam int PG_SETTLE_NS   = 250;
    localparam int PG_SETTLE_CYC  = (PG_SETTLE_NS * CLK_MHZ + 999) / 1000;
    localparam int STUCK_US       = 25;
    localparam int STUCK_CYC      = STUCK_US * CLK_MHZ;
    localparam int CNT_W          = 11;

    // ************************************************************
    // bus and field widths
    // ************************************************************
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;
    localparam int HOLD_W = 16;
    localparam int LTR_W  = 16;
    localparam int EV_W   = 5;

    // ************************************************************
    // register offsets
    // ************************************************************
    localparam logic [ADDR_W-1:0] CTRL_OFS    = 8'h00;
    localparam logic [ADDR_W-1:0] HOLD_OFS    = 8'h04;
    localparam logic [ADDR_W-1:0] LTR_SW_OFS  = 8'h08;
    localparam logic [ADDR_W-1:0] LTR_HW_OFS  = 8'h0c;
    localparam logic [ADDR_W-1:0] LTR_CUR_OFS = 8'h10;
    localparam logic [ADDR_W-1:0] INT_ST_OFS  = 8'h14;
    localparam logic [ADDR_W-1:0] INT_CLR_OFS = 8'h18;
    localparam logic [ADDR_W-1:0] INT_EN_OFS  = 8'h1c;
    localparam logic [ADDR_W-1:0] STATUS_OFS  = 8'h20;

    // ************************************************************
    // field positions
    // ************************************************************
    localparam int CTRL_ALT      = 0;
    localparam int CTRL_LTR_SW   = 1;
    localparam int CTRL_IDLE_SDA = 2;
    localparam int CTRL_IDLE_SCL = 3;
    localparam int CTRL_W        = 4;
    localparam int EV_TXDONE     = 0;
    localparam int EV_NACK       = 1;
    localparam int EV_ARB        = 2;
    localparam int EV_STUCK      = 3;
    localparam int EV_PG         = 4;
    localparam int ST_GATED      = 0;
    localparam int ST_BUSY       = 1;
    localparam int ST_SDA        = 2;
    localparam int ST_SCL        = 3;
    localparam int ST_DMA        = 4;
    localparam int ST_ALT        = 5;
    localparam int ST_W          = 6;

    // ************************************************************
    // reset values
    // ************************************************************
    localparam logic [CTRL_W-1:0] CTRL_RST    = 4'h0;
    localparam logic [HOLD_W-1:0] HOLD_RST    = 16'h0004;
    localparam logic [LTR_W-1:0]  LTR_SW_RST  = 16'h0000;
    localparam logic [LTR_W-1:0]  LTR_ACT_RST = 16'h0000;
    localparam logic [LTR_W-1:0]  LTR_IDL_RST = 16'h0000;
    localparam logic [DATA_W-1:0] RD_ZERO     = 32'h0000_0000;

    // power gate sequencing
    typedef enum logic [1:0] {PG_ON, PG_ENTER, PG_OFF, PG_EXIT} ihp_pg_t;
endpackage

/* verilog/ihp_sda_hold.sv */
// Purpose: delays data line changes by a programmable count after clock fall
// Assumes: scl_fall is a one-cycle pulse from the sensed clock line
// Notes:   a hold of zero lets the request pass one cycle late
`timescale 1ns/1ps
module ihp_sda_hold
    import ihp_pkg::*;
(
    input  wire logic              pclk,        // block clock
    input  wire logic              presetn,     // async reset, low
    input  wire logic              sda_req,     // engine asks data low
    input  wire logic              scl_fall,    // sensed clock fell
    input  wire logic [HOLD_W-1:0] hold_cyc,    // hold in clock cycles
    output logic                   sda_low      // held data drive
);
    logic [HOLD_W-1:0] cnt_reg;

    // restart hold window on every clock fall
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt_reg <= '0;
        end else if (scl_fall) begin
            cnt_reg <= hold_cyc;
        end else if (cnt_reg != '0) begin
            cnt_reg <= cnt_reg - 1'b1;
        end
    end

    // data follows request only outside the hold window
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sda_low <= 1'b0;
        end else if (cnt_reg == '0 && !scl_fall) begin
            sda_low <= sda_req;
        end
    end
endmodule

/* verilog/ihp_top.sv */
// Purpose: pin, power gate, latency report and interrupt side of one host
// Assumes: protocol engine drives the *_low requests; pins sampled on pclk
// Notes:   APB slave with zero wait states; unmapped address gives pslverr
//
// How it works
// - while gated, lines sit at the configured idle level.
// - during gate entry and exit the line drive is frozen.
// - latency tolerance is reported to the power manager from registers.
// - latency source is hardware state or driver value, by a control bit.
// - one interrupt output, high while an enabled event is pending.
// - cause is read from event status, status and the DMA flag.
// - pending events clear only by writing the clear register.
// - nack, lost data and stuck clock are latched as status.
// - data hold after clock fall is a writable cycle count.
// - lines are open drain: only driven low, pulled up outside.
// - controllers two to five may use an alternate pin pair.
//
// Implementation choices: the APB register port and the placing of the registers.
`timescale 1ns/1ps
module ihp_top
    import ihp_pkg::*;
#(
    parameter int CTRL_INDEX = 2                   // controller number 0..5
)(
    input  wire logic              pclk,                   // block clock
    input  wire logic              presetn,                // async reset, low
    input  wire logic              psel,                   // apb select
    input  wire logic              penable,                // apb enable
    input  wire logic              pwrite,                 // apb write
    input  wire logic [ADDR_W-1:0] paddr,                  // apb byte address
    input  wire logic [DATA_W-1:0] pwdata,                 // apb write data
    output logic      [DATA_W-1:0] prdata,                 // apb read data
    output logic                   pready,                 // apb ready
    output logic                   pslverr,                // apb error
    output logic                   irq,                    // service request
    input  wire logic              eng_sda_low,            // engine data low
    input  wire logic              eng_scl_low,            // engine clock low
    input  wire logic              eng_busy,               // transfer active
    input  wire logic              eng_data_phase,         // data bit window
    input  wire logic              eng_nack,               // nack pulse
    input  wire logic              eng_tx_done,            // transmit done pulse
    input  wire logic              dma_irq,                // dma pending level
    input  wire logic              pg_req,                 // power gate request
    output logic                   pg_gated,               // bus is gated
    output logic      [LTR_W-1:0]  ltr_value,              // reported latency
    output logic                   ltr_update,             // latency changed
    input  wire logic              link_data_line_in,      // primary data in
    output logic                   link_data_line_out,     // primary data out
    output logic                   link_data_line_oe,      // primary data drive
    input  wire logic              link_clock_line_in,     // primary clock in
    output logic                   link_clock_line_out,    // primary clock out
    output logic                   link_clock_line_oe,     // primary clock drive
    input  wire logic              link_alt_data_line_in,  // alternate data in
    output logic                   link_alt_data_line_out, // alternate data out
    output logic                   link_alt_data_line_oe,  // alternate data drive
    input  wire logic              link_alt_clock_line_in, // alternate clock in
    output logic                   link_alt_clock_line_out,// alternate clock out
    output logic                   link_alt_clock_line_oe  // alternate clock drive
);
    localparam bit HAS_ALT = (CTRL_INDEX >= 2);

    // ************************************************************
    // elaboration checks
    // ************************************************************
    if (CTRL_INDEX < 0 || CTRL_INDEX > 5) begin : g_bad_index
        $error("controller index must lie in 0..5");
    end
    if (PG_SETTLE_CYC < 1 || STUCK_CYC >= (1 << CNT_W)) begin : g_bad_time
        $error("timing counts do not fit the counters");
    end

    function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [ADDR_W-1:0] ofs);
        hit = (a == ofs);
    endfunction

    logic [CTRL_W-1:0] ctrl_reg;
    logic [HOLD_W-1:0] hold_reg;
    logic [LTR_W-1:0]  ltr_sw_reg;
    logic [LTR_W-1:0]  ltr_act_reg;
    logic [LTR_W-1:0]  ltr_idl_reg;
    logic [EV_W-1:0]   int_st_reg;
    logic [EV_W-1:0]   int_en_reg;
    logic [EV_W-1:0]   ev;
    logic [EV_W-1:0]   clr;
    logic              alt_reg;
    logic              drv_sda_reg;
    logic              drv_scl_reg;
    logic              scl_q_reg;
    logic              sda_held;
    logic              sda_in;
    logic              scl_in;
    logic              scl_fall;
    logic              scl_rise;
    logic              wr_acc;
    logic              setup;
    logic              pg_done;
    logic              stuck_hit;
    logic [CNT_W-1:0]  pg_cnt_reg;
    logic [CNT_W-1:0]  stuck_cnt_reg;
    logic [ST_W-1:0]   status;
    logic              addr_ok;
    logic [DATA_W-1:0] rd_next;
    ihp_pg_t           pg_reg;
    ihp_pg_t           pg_next;

    // ************************************************************
    // apb access decode
    // ************************************************************
    assign setup  = psel && !penable;
    assign wr_acc = psel && penable && pready && pwrite;
    assign clr    = (wr_acc && hit(paddr, INT_CLR_OFS)) ? pwdata[EV_W-1:0] : '0;

    // read mux and address check
    always_comb begin
        addr_ok = 1'b1;
        rd_next = RD_ZERO;
        case (paddr)
            CTRL_OFS:    rd_next[CTRL_W-1:0] = ctrl_reg;
            HOLD_OFS:    rd_next[HOLD_W-1:0] = hold_reg;
            LTR_SW_OFS:  rd_next[LTR_W-1:0] = ltr_sw_reg;
            LTR_HW_OFS:  rd_next = {ltr_idl_reg, ltr_act_reg};
            LTR_CUR_OFS: rd_next[LTR_W-1:0] = ltr_value;
            INT_ST_OFS:  rd_next[EV_W-1:0] = int_st_reg;
            INT_CLR_OFS: rd_next = RD_ZERO;
            INT_EN_OFS:  rd_next[EV_W-1:0] = int_en_reg;
            STATUS_OFS:  rd_next[ST_W-1:0] = status;
            default:     addr_ok = 1'b0;
        endcase
    end

    // answer in the first access cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata  <= RD_ZERO;
            pready  <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            pready  <= setup;
            pslverr <= setup && !addr_ok;
            if (setup && !pwrite) begin
                prdata <= rd_next;
            end
        end
    end

    // ************************************************************
    // writable registers
    // ************************************************************
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_reg    <= CTRL_RST;
            hold_reg    <= HOLD_RST;
            ltr_sw_reg  <= LTR_SW_RST;
            ltr_act_reg <= LTR_ACT_RST;
            ltr_idl_reg <= LTR_IDL_RST;
            int_en_reg  <= '0;
        end else if (wr_acc) begin
            if (hit(paddr, CTRL_OFS)) begin
                ctrl_reg <= pwdata[CTRL_W-1:0];
            end
            if (hit(paddr, HOLD_OFS)) begin
                hold_reg <= pwdata[HOLD_W-1:0];
            end
            if (hit(paddr, LTR_SW_OFS)) begin
                ltr_sw_reg <= pwdata[LTR_W-1:0];
            end
            if (hit(paddr, LTR_HW_OFS)) begin
                ltr_act_reg <= pwdata[LTR_W-1:0];
                ltr_idl_reg <= pwdata[DATA_W-1:LTR_W];
            end
            if (hit(paddr, INT_EN_OFS)) begin
                int_en_reg <= pwdata[EV_W-1:0];
            end
        end
    end

    // ************************************************************
    // pin pair selection
    // ************************************************************
    // switch pairs only between transfers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            alt_reg <= 1'b0;
        end else if (!eng_busy) begin
            alt_reg <= HAS_ALT && ctrl_reg[CTRL_ALT];
        end
    end

    // sensed levels of the pair in use
    assign sda_in = alt_reg ? link_alt_data_line_in : link_data_line_in;
    assign scl_in = alt_reg ? link_alt_clock_line_in : link_clock_line_in;

    // clock edge tracking
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            scl_q_reg <= 1'b1;
        end else begin
            scl_q_reg <= scl_in;
        end
    end

    assign scl_fall = scl_q_reg && !scl_in;
    assign scl_rise = !scl_q_reg && scl_in;

    // data hold after clock fall
    ihp_sda_hold u_hold (
        .pclk     (pclk),
        .presetn  (presetn),
        .sda_req  (eng_sda_low),
        .scl_fall (scl_fall),
        .hold_cyc (hold_reg),
        .sda_low  (sda_held)
    );

    // ************************************************************
    // power gate sequencing
    // ************************************************************
    always_comb begin
        pg_next = pg_reg;
        case (pg_reg)
            PG_ON:    if (pg_req && !eng_busy) pg_next = PG_ENTER;
            PG_ENTER: if (pg_cnt_reg == '0) pg_next = PG_OFF;
            PG_OFF:   if (!pg_req) pg_next = PG_EXIT;
            PG_EXIT:  if (pg_cnt_reg == '0) pg_next = PG_ON;
            default:  pg_next = PG_ON;
        endcase
    end

    assign pg_done = (pg_reg == PG_ENTER || pg_reg == PG_EXIT) && pg_cnt_reg == '0;

    // state and settle counter
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pg_reg     <= PG_ON;
            pg_cnt_reg <= '0;
            pg_gated   <= 1'b0;
        end else begin
            pg_reg   <= pg_next;
            pg_gated <= (pg_next != PG_ON);
            if (pg_next != pg_reg) begin
                pg_cnt_reg <= CNT_W'(PG_SETTLE_CYC - 1);
            end else if (pg_cnt_reg != '0) begin
                pg_cnt_reg <= pg_cnt_reg - 1'b1;
            end
        end
    end

    // line drive per power state
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            drv_sda_reg <= 1'b0;
            drv_scl_reg <= 1'b0;
        end else begin
            case (pg_reg)
                PG_ON: begin
                    drv_sda_reg <= sda_held;
                    drv_scl_reg <= eng_scl_low;
                end
                PG_OFF: begin
                    drv_sda_reg <= ctrl_reg[CTRL_IDLE_SDA];
                    drv_scl_reg <= ctrl_reg[CTRL_IDLE_SCL];
                end
                default: begin
                    drv_sda_reg <= drv_sda_reg;
                    drv_scl_reg <= drv_scl_reg;
                end
            endcase
        end
    end

    // open-drain pins, selected pair only
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            link_data_line_out      <= 1'b0;
            link_clock_line_out     <= 1'b0;
            link_alt_data_line_out  <= 1'b0;
            link_alt_clock_line_out <= 1'b0;
            link_data_line_oe       <= 1'b0;
            link_clock_line_oe      <= 1'b0;
            link_alt_data_line_oe   <= 1'b0;
            link_alt_clock_line_oe  <= 1'b0;
        end else begin
            link_data_line_out      <= 1'b0;
            link_clock_line_out     <= 1'b0;
            link_alt_data_line_out  <= 1'b0;
            link_alt_clock_line_out <= 1'b0;
            link_data_line_oe       <= drv_sda_reg && !alt_reg;
            link_clock_line_oe      <= drv_scl_reg && !alt_reg;
            link_alt_data_line_oe   <= drv_sda_reg && alt_reg;
            link_alt_clock_line_oe  <= drv_scl_reg && alt_reg;
        end
    end

    // ************************************************************
    // bus error detection
    // ************************************************************
    // clock held low by someone else
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            stuck_cnt_reg <= '0;
        end else if (scl_in || drv_scl_reg || pg_reg != PG_ON) begin
            stuck_cnt_reg <= '0;
        end else if (stuck_cnt_reg != CNT_W'(STUCK_CYC)) begin
            stuck_cnt_reg <= stuck_cnt_reg + 1'b1;
        end
    end

    assign stuck_hit = (stuck_cnt_reg == CNT_W'(STUCK_CYC - 1)) && !scl_in && !drv_scl_reg
                       && pg_reg == PG_ON;

    // event sources
    always_comb begin
        ev            = '0;
        ev[EV_TXDONE] = eng_tx_done;
        ev[EV_NACK]   = eng_nack;
        ev[EV_ARB]    = scl_rise && eng_data_phase && !drv_sda_reg && !sda_in;
        ev[EV_STUCK]  = stuck_hit;
        ev[EV_PG]     = pg_done;
    end

    // ************************************************************
    // interrupt status and output
    // ************************************************************
    // sticky events, set wins over clear
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            int_st_reg <= '0;
        end else begin
            int_st_reg <= (int_st_reg & ~clr) | ev;
        end
    end

    // single level interrupt
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq <= 1'b0;
        end else begin
            irq <= |(int_st_reg & int_en_reg) || dma_irq;
        end
    end

    // live status view
    always_comb begin
        status           = '0;
        status[ST_GATED] = pg_gated;
        status[ST_BUSY]  = eng_busy;
        status[ST_SDA]   = sda_in;
        status[ST_SCL]   = scl_in;
        status[ST_DMA]   = dma_irq;
        status[ST_ALT]   = alt_reg;
    end

    // ************************************************************
    // latency tolerance reporting
    // ************************************************************
    ihp_ltr u_ltr (
        .pclk    (pclk),
        .presetn (presetn),
        .sw_mode (ctrl_reg[CTRL_LTR_SW]),
        .active  (eng_busy && pg_reg == PG_ON),
        .sw_val  (ltr_sw_reg),
        .act_val (ltr_act_reg),
        .idl_val (ltr_idl_reg),
        .value   (ltr_value),
        .update  (ltr_update)
    );
endmodule
